// >>> rtl/spd_top.sv
// Serial programming link, instruction executor and visibility readback
`timescale 1ns/1ps

// ******************************************************************
// Command FIFO
// ******************************************************************
module spd_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clock,
  input  wire logic             i_reset_n,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  output logic      [WIDTH-1:0] o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  wire              push = i_valid && o_ready;
  wire              pop  = o_valid && i_ready;

  // Full and empty from pointer wrap bit
  assign o_ready = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
  assign o_valid = (wr_ptr_reg != rd_ptr_reg);
  assign o_data  = mem[rd_ptr_reg[AW-1:0]];

  // Storage write
  always_ff @(posedge i_clock)
  begin
    if (push)
      mem[wr_ptr_reg[AW-1:0]] <= i_data;
  end

  // Pointers
  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
    end
  end
endmodule // spd_fifo

// ******************************************************************
// Top
// ******************************************************************
module spd_top #(
  parameter logic [15:0] APP_ID_WORD = spd_pkg::APP_ID_VALUE
) (
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  input  wire logic        i_master_clear_n,
  input  wire logic        i_link_clock,
  input  wire logic        i_link_data,
  output logic             o_link_data,
  output logic             o_link_oe,
  output logic [23:0]      o_mem_addr,
  output logic             o_mem_rd,
  input  wire logic [15:0] i_mem_rdata,
  output logic             o_prog_mode,
  output logic             o_cmd_dropped
);
  import spd_pkg::*;

  // ****************************************************************
  // Link domain
  // ****************************************************************
  logic        lrst_s1, lrst_s2;
  logic [4:0]  bit_cnt_reg;
  logic [22:0] shift_reg;
  logic [3:0]  code_reg;
  logic [15:0] out_sh_reg;
  logic        oe_reg;
  logic [23:0] lnk_cmd_reg;
  logic        req_tog_reg, drop_tog_reg;
  logic        ack_s1, ack_s2;
  logic        vt_s1, vt_s2, vt_s3;
  logic [15:0] visi_link_reg;
  logic        ack_reg, visi_tog_reg;
  logic [15:0] visi_reg;

  wire [3:0]  code_now   = {shift_reg[2:0], i_link_data};
  wire        is_reg_out = (code_reg == CODE_REG_OUT);
  wire        frame_end  = (bit_cnt_reg == FRAME_LAST);
  wire        link_idle  = (req_tog_reg == ack_s2);
  wire        out_shift  = oe_reg && !frame_end;

  // Link reset and crossing synchronisers
  always_ff @(posedge i_link_clock)
  begin
    lrst_s1 <= i_reset_n && i_master_clear_n;
    lrst_s2 <= lrst_s1;
    ack_s1  <= ack_reg;
    ack_s2  <= ack_s1;
    vt_s1   <= visi_tog_reg;
    vt_s2   <= vt_s1;
    vt_s3   <= vt_s2;
  end

  // Bit counter, shifter and control code capture
  always_ff @(posedge i_link_clock)
  begin
    if (!lrst_s2)
    begin
      bit_cnt_reg <= '0;
      shift_reg   <= '0;
      code_reg    <= CODE_EXEC;
    end
    else
    begin
      bit_cnt_reg <= frame_end ? 5'h00 : bit_cnt_reg + CNT_STEP;
      shift_reg   <= {shift_reg[21:0], i_link_data};
      if (bit_cnt_reg == CODE_LAST)
        code_reg <= code_now;
    end
  end

  always_ff @(posedge i_link_clock)
  begin
    if (!lrst_s2)
    begin
      req_tog_reg  <= 1'b0;
      drop_tog_reg <= 1'b0;
      lnk_cmd_reg  <= '0;
    end
    else if (frame_end && code_reg == CODE_EXEC)
    begin
      if (link_idle)
      begin
        lnk_cmd_reg <= {shift_reg, i_link_data};
        req_tog_reg <= !req_tog_reg;
      end
      else
        drop_tog_reg <= !drop_tog_reg;
    end
  end

  always_ff @(posedge i_link_clock)
  begin
    if (!lrst_s2)
    begin
      visi_link_reg <= '0;
      out_sh_reg    <= '0;
      oe_reg        <= 1'b0;
    end
    else
    begin
      if (vt_s2 != vt_s3)
        visi_link_reg <= visi_reg;          // Stable while toggle settles
      if (bit_cnt_reg == TURN_LAST && is_reg_out)
      begin
        out_sh_reg <= visi_link_reg;
        oe_reg     <= 1'b1;
      end
      else if (out_shift)
        out_sh_reg <= {out_sh_reg[14:0], 1'b0};
      else if (frame_end)
      begin
        out_sh_reg <= '0;                   // Data line low outside the word
        oe_reg     <= 1'b0;
      end
    end
  end

  assign o_link_data = out_sh_reg[15];
  assign o_link_oe   = oe_reg;

  // Line stays low while not driving the word
  chk_idle_line_low: assert property (
    @(posedge i_link_clock) disable iff (!lrst_s2)
    !o_link_oe |-> !o_link_data)
    else $error("data line not low outside register-out word");

  // First bit driven after turnaround
  chk_reg_out_drive: assert property (
    @(posedge i_link_clock) disable iff (!lrst_s2)
    (bit_cnt_reg == TURN_LAST && is_reg_out && vt_s2 == vt_s3)
      |=> (o_link_oe && o_link_data == $past(visi_link_reg[15])) ##15 (o_link_oe && bit_cnt_reg == FRAME_LAST))
    else $error("register-out word not driven");

  // ****************************************************************
  // Core domain: synchronisers and mode
  // ****************************************************************
  logic       cm_s1, cm_s2, rq_s1, rq_s2, dr_s1, dr_s2, dr_s3;
  logic       prog_mode_reg, dropped_reg;
  wire        core_rst = !i_reset_n || !cm_s2;

  always_ff @(posedge i_clock)
  begin
    cm_s1 <= i_master_clear_n;
    cm_s2 <= cm_s1;
    rq_s1 <= req_tog_reg;
    rq_s2 <= rq_s1;
    dr_s1 <= drop_tog_reg;
    dr_s2 <= dr_s1;
    dr_s3 <= dr_s2;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
      prog_mode_reg <= 1'b0;
    else
      prog_mode_reg <= cm_s2;
  end

  // Sticky drop flag, reset or mode exit wins over set
  always_ff @(posedge i_clock)
  begin
    if (core_rst)
      dropped_reg <= 1'b0;
    else if (dr_s2 != dr_s3)
      dropped_reg <= 1'b1;
  end

  assign o_prog_mode   = prog_mode_reg;
  assign o_cmd_dropped = dropped_reg;

  // ****************************************************************
  // Command FIFO and handshake
  // ****************************************************************
  logic        fifo_ready, fifo_valid;
  logic [23:0] fifo_data;
  spd_state_t  st_reg, st_next;
  wire         pending = (rq_s2 != ack_reg);
  wire         push    = pending && fifo_ready;

  spd_fifo #(.WIDTH(FIELD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clock   (i_clock),
    .i_reset_n (!core_rst),
    .i_data    (lnk_cmd_reg),
    .i_valid   (pending),
    .o_ready   (fifo_ready),
    .o_data    (fifo_data),
    .o_valid   (fifo_valid),
    .i_ready   (st_reg == ST_IDLE)
  );

  // Acknowledge only once stored; the link drops new commands until then
  always_ff @(posedge i_clock)
  begin
    if (core_rst)
      ack_reg <= 1'b0;
    else if (push)
      ack_reg <= rq_s2;
  end

  // ****************************************************************
  // Executor
  // ****************************************************************
  logic [23:0] ir_reg;
  logic [15:0] w_reg [16];
  logic [7:0]  table_page_reg;
  logic [15:0] dst_addr_reg;
  logic        id_hit_reg, mem_rd_reg;
  logic [23:0] mem_addr_reg;

  wire [3:0]  src_n     = ir_reg[3:0];
  wire [3:0]  dst_n     = ir_reg[10:7];
  wire [15:0] w_src     = w_reg[src_n];
  wire [15:0] w_dst     = w_reg[dst_n];
  wire        st_exec   = (st_reg == ST_EXEC);
  wire        st_fill   = (st_reg == ST_FILL);
  wire        is_movlit = (ir_reg[23:20] == OP_MOVLIT);
  wire        is_movf   = (ir_reg[23:19] == OP_MOVF);
  wire [15:0] movf_addr = {ir_reg[18:4], 1'b0};
  wire        is_clr    = ((ir_reg & CLR_MASK) == CLR_OP);
  wire        is_tbl    = (ir_reg[23:16] == OP_TBL_READ) && !ir_reg[14];
  wire        src_inc   = (ir_reg[6:4] == MODE_POSTINC);
  wire        dst_inc   = (ir_reg[13:11] == MODE_POSTINC);
  wire [23:0] tbl_addr  = {table_page_reg, w_src};
  wire [15:0] fill_data = id_hit_reg ? APP_ID_WORD : i_mem_rdata;
  wire        fill_visi = st_fill && (dst_addr_reg == VISI_ADDR);
  wire        movf_visi = st_exec && is_movf && (movf_addr == VISI_ADDR);
  wire        visi_we   = fill_visi || movf_visi;
  wire [15:0] visi_next = fill_visi ? fill_data : w_src;

  // Next state
  always_comb
  begin
    case (st_reg)
      ST_IDLE: st_next = fifo_valid ? ST_EXEC : ST_IDLE;
      ST_EXEC: st_next = is_tbl ? ST_WAIT : ST_IDLE;
      ST_WAIT: st_next = ST_FILL;
      ST_FILL: st_next = ST_IDLE;
      default: st_next = ST_IDLE;
    endcase
  end

  // State and instruction latch
  always_ff @(posedge i_clock)
  begin
    if (core_rst)
    begin
      st_reg <= ST_IDLE;
      ir_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
      if (st_reg == ST_IDLE && fifo_valid)
        ir_reg <= fifo_data;
    end
  end

  // ID word served from fixed address
  always_ff @(posedge i_clock)
  begin
    if (core_rst)
    begin
      id_hit_reg   <= 1'b0;
      mem_rd_reg   <= 1'b0;
      mem_addr_reg <= '0;
      dst_addr_reg <= '0;
    end
    else
    begin
      mem_rd_reg <= st_exec && is_tbl && (tbl_addr != APP_ID_ADDR);
      if (st_exec && is_tbl)
      begin
        id_hit_reg   <= (tbl_addr == APP_ID_ADDR);
        mem_addr_reg <= tbl_addr;
        dst_addr_reg <= w_dst;
      end
    end
  end

  assign o_mem_rd   = mem_rd_reg;
  assign o_mem_addr = mem_addr_reg;

  always_ff @(posedge i_clock)
  begin
    if (core_rst)
    begin
      for (int i = 0; i < 16; i++)
        w_reg[i] <= '0;
      table_page_reg <= '0;
    end
    else if (st_exec)
    begin
      if (is_movlit)
        w_reg[ir_reg[3:0]] <= ir_reg[19:4];
      if (is_movf && movf_addr == PAGE_ADDR)
        table_page_reg <= w_src[7:0];
      if (is_clr)
        w_reg[dst_n] <= '0;
      if (is_tbl && src_inc)
        w_reg[src_n] <= w_src + PTR_STEP;
      if (is_tbl && dst_inc)
        w_reg[dst_n] <= w_dst + PTR_STEP;
    end
    else if (st_fill && !fill_visi)
      w_reg[dst_addr_reg[4:1]] <= fill_data;
  end

  always_ff @(posedge i_clock)
  begin
    if (core_rst)
    begin
      visi_reg     <= '0;
      visi_tog_reg <= 1'b0;
    end
    else if (visi_we)
    begin
      visi_reg     <= visi_next;
      visi_tog_reg <= !visi_tog_reg;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_id_word_read: assert property (
    @(posedge i_clock) disable iff (core_rst)
    (st_exec && is_tbl && tbl_addr == APP_ID_ADDR && w_dst == VISI_ADDR)
      |-> !o_mem_rd ##3 (visi_reg == APP_ID_WORD))
    else $error("application ID word not delivered");

  chk_mem_word: assert property (
    @(posedge i_clock) disable iff (core_rst)
    (o_mem_rd && dst_addr_reg == VISI_ADDR) |=> st_fill ##1 (visi_reg == $past(i_mem_rdata)))
    else $error("data word not stored");

  chk_exec_visi: assert property (
    @(posedge i_clock) disable iff (core_rst)
    movf_visi |=> (visi_reg == $past(w_src)) && (st_reg == ST_IDLE))
    else $error("move to visibility not executed");

  chk_visi_toggle: assert property (
    @(posedge i_clock) disable iff (core_rst)
    visi_we |=> (visi_tog_reg != $past(visi_tog_reg)))
    else $error("visibility change not signalled");

  chk_clear_exit: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    !cm_s2 |=> (!o_prog_mode && st_reg == ST_IDLE && !o_mem_rd))
    else $error("programming mode not left");

  chk_push_once: assert property (
    @(posedge i_clock) disable iff (core_rst)
    push |=> !pending)
    else $error("command pushed twice");
endmodule // spd_top

// >>> rtl/spd_pkg.sv
// Constants for the serial programming readback block
package spd_pkg;
  // ****************************************************************
  // Link framing
  // ****************************************************************
  localparam int          CODE_W       = 4;
  localparam int          FIELD_W      = 24;
  localparam int          WORD_W       = 16;
  localparam logic [4:0]  CODE_LAST    = 5'h03;
  localparam logic [4:0]  TURN_LAST    = 5'h0b;
  localparam logic [4:0]  FRAME_LAST   = 5'h1b;
  localparam logic [4:0]  CNT_STEP     = 5'h01;
  localparam logic [3:0]  CODE_EXEC    = 4'h0;
  localparam logic [3:0]  CODE_REG_OUT = 4'h1;
  // ****************************************************************
  // Instruction decode and addresses
  // ****************************************************************
  localparam logic [3:0]  OP_MOVLIT    = 4'h2;
  localparam logic [4:0]  OP_MOVF      = 5'h11;
  localparam logic [7:0]  OP_TBL_READ  = 8'hba;
  localparam logic [23:0] CLR_MASK     = 24'hfff87f;
  localparam logic [23:0] CLR_OP       = 24'heb0000;
  localparam logic [2:0]  MODE_POSTINC = 3'h3;
  localparam logic [15:0] PTR_STEP     = 16'h0002;
  localparam logic [15:0] PAGE_ADDR    = 16'h0032;
  localparam logic [15:0] VISI_ADDR    = 16'h0784;
  localparam logic [23:0] APP_ID_ADDR  = 24'h8005be;
  localparam logic [15:0] APP_ID_VALUE = 16'h00bb;
  localparam int          FIFO_DEPTH   = 16;
  // ****************************************************************
  // Executor states
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_FILL = 4'b1000
  } spd_state_t;
endpackage

// >>> tb/spd_prog_model.sv
// Programmer model that frames commands on the serial programming link
`timescale 1ns/1ps
module spd_prog_model
  import spd_pkg::*;
(
  output logic        o_link_clock,
  output logic        o_link_data,
  input  wire logic   i_link_data,
  input  wire logic   i_link_oe,
  output logic [15:0] o_word,
  output logic        o_word_valid,
  output logic        o_turn_ok
);
  // Idle levels, link clock stopped
  initial
  begin
    o_link_clock = 1'b0;
    o_link_data  = 1'b0;
    o_word       = 16'h0000;
    o_word_valid = 1'b0;
    o_turn_ok    = 1'b1;
  end
  // ****************************************************************
  // Bare link clock pulses for the reset synchronisers
  // ****************************************************************
  task automatic edges(input int n);
    repeat (n)
    begin
      #15 o_link_clock = 1'b1;
      #15 o_link_clock = 1'b0;
    end
  endtask
  // ****************************************************************
  // One frame: code then field, MSB first, sampled on rising edge
  // ****************************************************************
  // 4-bit code plus 24-bit field
  task automatic send(input logic [3:0] code, input logic [23:0] field);
    logic [27:0] frame;
    logic [15:0] rx;
    logic        ok;
    frame = {code, field};
    rx    = 16'h0000;
    ok    = 1'b1;
    for (int i = 0; i < 28; i++)
    begin
      o_link_data = frame[27-i];
      #15 o_link_clock = 1'b1;
      #15 o_link_clock = 1'b0;
      if (code == CODE_REG_OUT)
      begin
        // Turnaround low, then 16 data slots
        ok = ok & (i_link_oe === (i >= 11 && i <= 26));
        if (i >= 4 && i <= 10)
          ok = ok & (i_link_data === 1'b0);
        if (i >= 11 && i <= 26)
          rx = {rx[14:0], i_link_data};
      end
    end
    o_link_data = ~frame[0];  // Released line shows inverse
    if (code == CODE_REG_OUT)
    begin
      o_word       = rx;
      o_turn_ok    = ok;
      o_word_valid = 1'b1;
      #1 o_word_valid = 1'b0;
    end
  endtask
endmodule // spd_prog_model

// >>> tb/spd_top_tb_top.sv
// Self-checking testbench for the serial programming readback block
`timescale 1ns/1ps
module spd_top_tb_top;
  import spd_pkg::*;
  logic        i_clock          = 1'b0;
  logic        i_reset_n        = 1'b0;
  logic        i_master_clear_n = 1'b0;
  logic [15:0] i_mem_rdata      = 16'h0000;
  wire         link_clock, link_in, link_out, link_oe, mem_rd, prog_mode, cmd_dropped, word_valid, turn_ok;
  wire  [23:0] mem_addr;
  wire  [15:0] word;
  int          miscompares = 0;
  int          compares    = 0;
  integer      seed        = 32'h5db4e80d;
  logic [23:0] addr_q[$];
  logic [15:0] word_q[$];
  logic [15:0] src;

  // Core clock, 5 ns
  always #2.5 i_clock = ~i_clock;

  spd_top dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_master_clear_n(i_master_clear_n),
    .i_link_clock(link_clock), .i_link_data(link_in), .o_link_data(link_out), .o_link_oe(link_oe),
    .o_mem_addr(mem_addr), .o_mem_rd(mem_rd), .i_mem_rdata(i_mem_rdata), .o_prog_mode(prog_mode),
    .o_cmd_dropped(cmd_dropped));
  spd_prog_model m (.o_link_clock(link_clock), .o_link_data(link_in), .i_link_data(link_out),
    .i_link_oe(link_oe), .o_word(word), .o_word_valid(word_valid), .o_turn_ok(turn_ok));

  // ****************************************************************
  // Compare, verdict and watchdog
  // ****************************************************************
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge i_clock);
    miscompares++;
    complete_run();
  end
  // ****************************************************************
  // Memory responder and read address monitor
  // ****************************************************************
  always @(posedge i_clock)
  begin
    if (mem_rd === 1'b1)
    begin
      if (addr_q.size() == 0)
        check(mem_addr, 24'hffffff);
      else
        check(mem_addr, addr_q.pop_front());
      i_mem_rdata <= #1 mem_addr[15:0] ^ 16'hc3a5;
    end
    else
      i_mem_rdata <= #1 16'($random(seed));
  end
  // Returned word against oldest note
  always @(posedge word_valid)
  begin
    check({8'h00, word}, {8'h00, word_q.pop_front()});
    check({23'h0, turn_ok}, 24'h000001);
  end
  // ****************************************************************
  // Sequence helpers
  // ****************************************************************
  task automatic ex(input logic [23:0] ins);
    m.send(CODE_EXEC, ins);
  endtask
  task automatic register_out_code(input logic [15:0] exp);
    word_q.push_back(exp);
    m.send(CODE_REG_OUT, 24'h000000);
    ex(24'h000000);
  endtask
  task automatic leave_vector;
    ex(24'h040100);
    ex(24'h040100);
    ex(24'h000000);
  endtask
  task automatic wait_mode(input logic lvl);
    for (int k = 0; k < 20 && prog_mode !== lvl; k++)
    begin
      @(posedge i_clock);
      #1;
    end
    check({23'h0, prog_mode}, {23'h0, lvl});
    if (prog_mode !== lvl)
      complete_run();
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    m.edges(4);
    repeat (16) @(posedge i_clock);
    #1 i_reset_n = 1'b1;
    i_master_clear_n = 1'b1;
    wait_mode(1'b1);
    m.edges(2);
    // Data memory read of four words
    leave_vector();
    src = 16'($random(seed)) & 16'h0ffe;
    ex(24'h2007f0);
    ex(24'h880190);
    ex({4'h2, src, 4'h6});
    ex(24'heb0380);
    ex(24'h000000);
    for (int n = 0; n < 4; n++)
    begin
      addr_q.push_back({8'h7f, src + 16'(2 * n)});
      ex(24'hba1bb6);
      ex(24'h000000);
      ex(24'h000000);
    end
    for (int n = 0; n < 4; n++)
    begin
      ex(24'h883c20 | 24'(n));
      ex(24'h000000);
      register_out_code((src + 16'(2 * n)) ^ 16'hc3a5);
    end
    ex(24'h040100);
    ex(24'h000000);
    // Unknown code ignored, visibility keeps last word
    m.send(4'h5, 24'h883c20);
    ex(24'h000000);
    register_out_code((src + 16'h0006) ^ 16'hc3a5);
    // Application ID read without memory port
    leave_vector();
    ex(24'h200800);
    ex(24'h880190);
    ex(24'h205be0);
    ex(24'h207841);
    ex(24'h000000);
    ex(24'hba0890);
    ex(24'h000000);
    ex(24'h000000);
    register_out_code(APP_ID_VALUE);
    // Data word read straight into visibility
    ex(24'h2007f0);
    ex(24'h880190);
    ex({4'h2, src, 4'h0});
    addr_q.push_back({8'h7f, src});
    ex(24'hba0890);
    ex(24'h000000);
    ex(24'h000000);
    register_out_code(src ^ 16'hc3a5);
    // Master clear leaves the mode and clears working registers
    @(posedge i_clock);
    #1 i_master_clear_n = 1'b0;
    wait_mode(1'b0);
    m.edges(4);
    @(posedge i_clock);
    #1 i_master_clear_n = 1'b1;
    wait_mode(1'b1);
    m.edges(2);
    ex(24'h883c21);
    ex(24'h000000);
    register_out_code(16'h0000);
    repeat (20) @(posedge i_clock);
    check({23'h0, cmd_dropped}, 24'h000000);
    check(24'(word_q.size() + addr_q.size()), 24'h000000);
    complete_run();
  end
endmodule // spd_top_tb_top
